// file: design/cmrro_regs.svh
// Register offsets, field positions, reset values and window addresses of the move/return/reset unit
`ifndef CMRRO_REGS_SVH
`define CMRRO_REGS_SVH

`define CMRRO_OFF_ACC      8'h00
`define CMRRO_OFF_PTR0     8'h04
`define CMRRO_OFF_PTR1     8'h08
`define CMRRO_OFF_OPTION   8'h0c
`define CMRRO_OFF_CTRL     8'h10
`define CMRRO_OFF_PC       8'h14
`define CMRRO_OFF_LASTWR   8'h18

`define CMRRO_CTRL_GIE_BIT 0
`define CMRRO_CTRL_RI_BIT  1

`define CMRRO_IRQCTL_GIE_BIT 7

`define CMRRO_WINDOW0_ADDR 7'h00
`define CMRRO_WINDOW1_ADDR 7'h01

`define CMRRO_ACC_RST      8'h00
`define CMRRO_PTR_RST      16'h0000
`define CMRRO_OPTION_RST   8'hff
`define CMRRO_PC_RST       15'h0000
`define CMRRO_RI_RST       1'b1
`define CMRRO_GIE_RST      1'b0

`define CMRRO_PTR_ONE      16'h0001
`define CMRRO_RESP_OKAY    2'b00
`define CMRRO_RESP_SLVERR  2'b10

`endif

// file: design/cmrro_pkg.sv
// Types shared by the move/return/reset unit and its users
package cmrro_pkg;

    typedef enum logic [2:0] {
        CMRRO_OP_NOP,
        CMRRO_OP_STORE_DIRECT,
        CMRRO_OP_STORE_INDIRECT,
        CMRRO_OP_OPTION_LOAD,
        CMRRO_OP_SOFT_RESET,
        CMRRO_OP_RETURN_IRQ
    } cmrro_op_t;

    typedef enum logic [1:0] {
        CMRRO_MM_PRE_INC  = 2'b00,
        CMRRO_MM_PRE_DEC  = 2'b01,
        CMRRO_MM_POST_INC = 2'b10,
        CMRRO_MM_POST_DEC = 2'b11
    } cmrro_mode_t;

    typedef struct packed {
        cmrro_op_t   op;
        logic [6:0]  file_addr;
        logic        ptr_sel;
        cmrro_mode_t ptr_update_mode;
        logic        relative;
        logic [5:0]  offset;
    } cmrro_instr_t;

    typedef struct packed {
        logic        valid;
        logic        indirect;
        logic [15:0] addr;
        logic [7:0]  data;
    } cmrro_memwr_t;

endpackage : cmrro_pkg

// file: design/cmrro_exec.sv
// Execution unit for accumulator stores, option load, software reset and return from interrupt
`timescale 1ns/100ps
`include "cmrro_regs.svh"
`default_nettype none

module cmrro_exec (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Instruction issue
    input  wire cmrro_pkg::cmrro_instr_t instr,
    input  wire logic                  instr_valid,
    output logic                       instr_ready,
    // Hardware stack
    input  wire logic [14:0]           stack_top,
    output logic                       stack_pop,
    // Program counter
    output logic [14:0]                pc,
    output logic                       pc_load,
    // Memory write port
    output cmrro_pkg::cmrro_memwr_t    mem_wr,
    // Core state
    output logic [7:0]                 option_reg,
    output logic [7:0]                 irq_control_reg,
    output logic                       soft_reset_flag,
    output logic                       soft_reset_req
);
    import cmrro_pkg::*;

    // ==========================================================
    // Instruction decode
    // ==========================================================
    logic [7:0]  acc;
    logic [15:0] pointer_reg [2];
    logic        global_irq_enable;
    logic        ret_second;

    wire logic issue      = instr_valid && instr_ready;
    wire logic do_direct  = issue && (instr.op == CMRRO_OP_STORE_DIRECT);
    wire logic do_ind     = issue && (instr.op == CMRRO_OP_STORE_INDIRECT);
    wire logic do_option  = issue && (instr.op == CMRRO_OP_OPTION_LOAD);
    wire logic do_reset   = issue && (instr.op == CMRRO_OP_SOFT_RESET);
    wire logic do_return  = issue && (instr.op == CMRRO_OP_RETURN_IRQ);

    // Second cycle of a return holds off the next issue
    assign instr_ready = !ret_second;

    // Direct store to a window address lands on the pointer's target
    wire logic win0 = (instr.file_addr == `CMRRO_WINDOW0_ADDR);
    wire logic win1 = (instr.file_addr == `CMRRO_WINDOW1_ADDR);
    wire logic direct_win = do_direct && (win0 || win1);

    // ==========================================================
    // Pointer arithmetic (plain adders, flag logic never sees them)
    // ==========================================================
    wire logic [15:0] sel_ptr  = pointer_reg[instr.ptr_sel];
    wire logic [15:0] ptr_inc  = sel_ptr + `CMRRO_PTR_ONE;
    wire logic [15:0] ptr_dec  = sel_ptr - `CMRRO_PTR_ONE;
    wire logic [15:0] off_sext = {{10{instr.offset[5]}}, instr.offset};
    wire logic [15:0] ptr_rel  = sel_ptr + off_sext;
    wire logic        is_dec   = instr.ptr_update_mode[0];
    wire logic        is_pre   = !instr.ptr_update_mode[1];
    wire logic [15:0] ptr_step = is_dec ? ptr_dec : ptr_inc;

    wire logic [15:0] ind_addr =
        instr.relative ? ptr_rel : (is_pre ? ptr_step : sel_ptr);
    wire logic [15:0] ind_next = instr.relative ? sel_ptr : ptr_step;
    wire logic [15:0] win_addr = win1 ? pointer_reg[1] : pointer_reg[0];

    wire logic [15:0] next_wr_addr =
        do_ind     ? ind_addr :
        direct_win ? win_addr :
                     {9'h0, instr.file_addr};

    // ==========================================================
    // AXI4-Lite decode
    // ==========================================================
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic [15:0] last_wr_addr;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take  = s_axi_wvalid && s_axi_wready;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;

    wire logic [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
    wire logic [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
    wire logic [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
    wire logic        wr_fire  = (aw_held || aw_take) && (w_held || w_take);

    wire logic wr_acc  = wr_fire && (wr_addr == `CMRRO_OFF_ACC);
    wire logic wr_p0   = wr_fire && (wr_addr == `CMRRO_OFF_PTR0);
    wire logic wr_p1   = wr_fire && (wr_addr == `CMRRO_OFF_PTR1);
    wire logic wr_ctrl = wr_fire && (wr_addr == `CMRRO_OFF_CTRL);
    wire logic wr_hit  = wr_acc || wr_p0 || wr_p1 || wr_ctrl;

    wire logic [31:0] rd_mux =
        (s_axi_araddr == `CMRRO_OFF_ACC)    ? {24'h000000, acc} :
        (s_axi_araddr == `CMRRO_OFF_PTR0)   ? {16'h0000, pointer_reg[0]} :
        (s_axi_araddr == `CMRRO_OFF_PTR1)   ? {16'h0000, pointer_reg[1]} :
        (s_axi_araddr == `CMRRO_OFF_OPTION) ? {24'h000000, option_reg} :
        (s_axi_araddr == `CMRRO_OFF_CTRL)   ? {30'h0, soft_reset_flag, global_irq_enable} :
        (s_axi_araddr == `CMRRO_OFF_PC)     ? {17'h0, pc} :
        (s_axi_araddr == `CMRRO_OFF_LASTWR) ? {16'h0000, last_wr_addr} :
                                              32'h00000000;
    wire logic rd_hit =
        (s_axi_araddr == `CMRRO_OFF_ACC)    || (s_axi_araddr == `CMRRO_OFF_PTR0) ||
        (s_axi_araddr == `CMRRO_OFF_PTR1)   || (s_axi_araddr == `CMRRO_OFF_OPTION) ||
        (s_axi_araddr == `CMRRO_OFF_CTRL)   || (s_axi_araddr == `CMRRO_OFF_PC) ||
        (s_axi_araddr == `CMRRO_OFF_LASTWR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CMRRO_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_held <= (aw_held || aw_take) && !wr_fire;
            w_held  <= (w_held || w_take) && !wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `CMRRO_RESP_OKAY : `CMRRO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CMRRO_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `CMRRO_RESP_OKAY : `CMRRO_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Accumulator and pointers
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= `CMRRO_ACC_RST;
        end else if (wr_acc && wr_strb[0]) begin
            acc <= wr_data[7:0];
        end
    end

    // Instruction update beats a same-cycle software write
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        wire logic ins_upd = do_ind && (instr.ptr_sel == 1'(i));
        wire logic sw_upd  = (i == 0) ? wr_p0 : wr_p1;
        wire logic [15:0] sw_val = {wr_strb[1] ? wr_data[15:8] : pointer_reg[i][15:8],
                                    wr_strb[0] ? wr_data[7:0]  : pointer_reg[i][7:0]};
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pointer_reg[i] <= `CMRRO_PTR_RST;
            end else if (ins_upd) begin
                pointer_reg[i] <= ind_next;
            end else if (sw_upd) begin
                pointer_reg[i] <= sw_val;
            end
        end
    end

    // ==========================================================
    // Memory write port; stores drive no flag outputs at all
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_wr       <= '0;
            last_wr_addr <= `CMRRO_PTR_RST;
        end else begin
            mem_wr.valid <= do_direct || do_ind;
            if (do_direct || do_ind) begin
                mem_wr.indirect <= do_ind || direct_win;
                mem_wr.addr     <= next_wr_addr;
                mem_wr.data     <= acc;
                last_wr_addr    <= next_wr_addr;
            end
        end
    end

    // ==========================================================
    // Option, reset flag, return and interrupt enable
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_reg <= `CMRRO_OPTION_RST;
        end else if (do_option) begin
            option_reg <= acc;
        end
    end

    // Clear from the instruction wins: both come from software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_flag <= `CMRRO_RI_RST;
            soft_reset_req  <= 1'b0;
        end else begin
            soft_reset_req <= do_reset;
            if (do_reset) begin
                soft_reset_flag <= 1'b0;
            end else if (wr_ctrl && wr_strb[0]) begin
                soft_reset_flag <= wr_data[`CMRRO_CTRL_RI_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_irq_enable <= `CMRRO_GIE_RST;
        end else if (do_return) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ctrl && wr_strb[0]) begin
            global_irq_enable <= wr_data[`CMRRO_CTRL_GIE_BIT];
        end
    end

    always_comb begin
        irq_control_reg = 8'h00;
        irq_control_reg[`CMRRO_IRQCTL_GIE_BIT] = global_irq_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ret_second <= 1'b0;
            stack_pop  <= 1'b0;
            pc_load    <= 1'b0;
            pc         <= `CMRRO_PC_RST;
        end else begin
            ret_second <= do_return;
            stack_pop  <= do_return;
            pc_load    <= do_return;
            if (do_return) begin
                pc <= stack_top;
            end
        end
    end

endmodule : cmrro_exec

`default_nettype wire

// file: tb/cmrro_exec_chk.sv
// Assertion checker for the move/return/reset execution unit
`timescale 1ns/100ps
`default_nettype none

module cmrro_exec_chk (
    // Clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // Instruction issue
    input wire cmrro_pkg::cmrro_instr_t instr,
    input wire logic                    instr_valid,
    input wire logic                    instr_ready,
    // Stack and program counter
    input wire logic [14:0]             stack_top,
    input wire logic                    stack_pop,
    input wire logic [14:0]             pc,
    input wire logic                    pc_load,
    // Core state
    input wire cmrro_pkg::cmrro_memwr_t mem_wr,
    input wire logic [7:0]              option_reg,
    input wire logic [7:0]              irq_control_reg,
    input wire logic                    soft_reset_flag,
    input wire logic                    soft_reset_req
);
    import cmrro_pkg::*;
    // ========================================
    // Issue history
    logic        iss_q;
    cmrro_op_t   op_q;
    logic [6:0]  fa_q;
    logic [14:0] top_q;
    wire logic   ret_q = iss_q && (op_q == CMRRO_OP_RETURN_IRQ);
    wire logic   rst_q = iss_q && (op_q == CMRRO_OP_SOFT_RESET);
    wire logic   opt_q = iss_q && (op_q == CMRRO_OP_OPTION_LOAD);
    wire logic   dir_q = iss_q && (op_q == CMRRO_OP_STORE_DIRECT);
    wire logic   ind_q = iss_q && (op_q == CMRRO_OP_STORE_INDIRECT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iss_q <= 1'b0;
        end else begin
            iss_q <= instr_valid & instr_ready;
        end
        op_q  <= instr.op;
        fa_q  <= instr.file_addr;
        top_q <= stack_top;
    end

    // ========================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_direct_addr: assert property (
        dir_q && fa_q > 7'h01 |-> mem_wr.valid && !mem_wr.indirect && mem_wr.addr == {9'h0, fa_q})
        else $error("direct store address wrong");
    a_store_pulse: assert property (
        mem_wr.valid |-> dir_q || ind_q) else $error("memory write without a store");
    a_option_hold: assert property (
        !opt_q |-> $stable(option_reg)) else $error("option register changed without load");
    a_ret_load: assert property (
        ret_q |-> pc_load && stack_pop && pc == top_q) else $error("return did not load pc");
    a_ret_stall: assert property (
        ret_q |-> !instr_ready ##1 instr_ready) else $error("return not two cycles");
    a_pop_cause: assert property (
        stack_pop || pc_load |-> ret_q) else $error("stack pop without return");
    a_gie_set: assert property (
        ret_q |-> irq_control_reg == 8'h80) else $error("return did not enable interrupts");
    a_irq_bits: assert property (
        irq_control_reg[6:0] == 7'h00) else $error("irq control low bits not zero");
    a_reset_req: assert property (
        rst_q |-> soft_reset_req && !soft_reset_flag) else $error("soft reset not requested");
endmodule : cmrro_exec_chk

`default_nettype wire

// file: tb/test_cpu_move_return_reset_ops.sv
// Self-checking bench for the move/return/reset execution unit
`timescale 1ns/100ps
`include "cmrro_regs.svh"
`default_nettype none

module test_cpu_move_return_reset_ops;
    import cmrro_pkg::*;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic [7:0]   awaddr = 8'h00;
    logic [7:0]   araddr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, instr_ready, stack_pop, pc_load;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    cmrro_instr_t instr = '0;
    logic         instr_valid = 1'b0;
    logic [14:0]  stack_top = 15'h0000;
    logic [14:0]  pc;
    cmrro_memwr_t mem_wr;
    logic [7:0]   option_reg, irq_control_reg;
    logic         soft_reset_flag, soft_reset_req;
    int           miscompares = 0;
    int           checked = 0;
    logic [15:0]  exp_addr [4] = '{16'h0000, 16'hffff, 16'hffff, 16'h0000};

    cmrro_exec cmrro_exec_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .stack_top(stack_top),
        .stack_pop(stack_pop), .pc(pc), .pc_load(pc_load), .mem_wr(mem_wr), .option_reg(option_reg),
        .irq_control_reg(irq_control_reg), .soft_reset_flag(soft_reset_flag),
        .soft_reset_req(soft_reset_req));

    always #5 aclk = ~aclk;

    // ========================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!b_ok);
        bready <= 1'b0;
        chk("bresp", r, er);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ok, rv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ok = arvalid & arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ok) arvalid <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
        chk("rdata", d, exp);
        chk("rresp", r, er);
    endtask : axr

    // Effects are sampled just after the taking edge
    task automatic issue(input cmrro_op_t op, input logic [6:0] fa, input logic sel, input logic [1:0] m,
                         input logic rel, input logic [5:0] off);
        @(posedge aclk);
        instr <= '{op, fa, sel, cmrro_mode_t'(m), rel, off};
        instr_valid <= 1'b1;
        @(posedge aclk);
        instr_valid <= 1'b0;
        #1;
    endtask : issue

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ========================================
    // Watchdog, far beyond the fewer than 100 cycles needed
    initial begin
        #100us;
        miscompares++;
        stop_test();
    end

    // ========================================
    // Tests
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        stack_top <= 15'h1abc;
        axr(`CMRRO_OFF_OPTION, 32'hff, `CMRRO_RESP_OKAY);
        axr(`CMRRO_OFF_CTRL, 32'h2, `CMRRO_RESP_OKAY);
        axr(8'h1c, 32'h0, `CMRRO_RESP_SLVERR);
        axw(8'h1c, 32'h55, `CMRRO_RESP_SLVERR);
        $display("test reset done");
        axw(`CMRRO_OFF_ACC, 32'h4f, `CMRRO_RESP_OKAY);
        issue(CMRRO_OP_STORE_DIRECT, 7'h7f, 1'b0, 2'b00, 1'b0, 6'h00);
        chk("direct", mem_wr, {1'b1, 1'b0, 16'h007f, 8'h4f});
        issue(CMRRO_OP_OPTION_LOAD, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00);
        chk("option_reg", option_reg, 32'h4f);
        $display("test direct and option done");
        // Chain of modes crossing both ends of the pointer range
        axw(`CMRRO_OFF_PTR0, 32'hffff, `CMRRO_RESP_OKAY);
        for (int m = 0; m < 4; m++) begin
            issue(CMRRO_OP_STORE_INDIRECT, 7'h00, 1'b0, m[1:0], 1'b0, 6'h00);
            chk("indirect", mem_wr, {1'b1, 1'b1, exp_addr[m], 8'h4f});
        end
        axr(`CMRRO_OFF_PTR0, 32'hffff, `CMRRO_RESP_OKAY);
        axw(`CMRRO_OFF_PTR1, 32'h0100, `CMRRO_RESP_OKAY);
        issue(CMRRO_OP_STORE_INDIRECT, 7'h00, 1'b1, 2'b11, 1'b1, 6'h20);
        chk("relative", mem_wr, {1'b1, 1'b1, 16'h00e0, 8'h4f});
        issue(CMRRO_OP_STORE_INDIRECT, 7'h00, 1'b1, 2'b00, 1'b1, 6'h1f);
        chk("relative", mem_wr, {1'b1, 1'b1, 16'h011f, 8'h4f});
        axr(`CMRRO_OFF_PTR1, 32'h0100, `CMRRO_RESP_OKAY);
        issue(CMRRO_OP_STORE_DIRECT, 7'h01, 1'b0, 2'b00, 1'b0, 6'h00);
        chk("window", mem_wr, {1'b1, 1'b1, 16'h0100, 8'h4f});
        $display("test indirect done");
        issue(CMRRO_OP_SOFT_RESET, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00);
        chk("soft_reset", {soft_reset_req, soft_reset_flag}, 32'h2);
        issue(CMRRO_OP_RETURN_IRQ, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00);
        chk("return", {pc_load, stack_pop, instr_ready, pc}, {3'b110, 15'h1abc});
        chk("irq_control_reg", irq_control_reg, 32'h80);
        @(posedge aclk);
        #1;
        chk("instr_ready", instr_ready, 32'h1);
        axr(`CMRRO_OFF_CTRL, 32'h1, `CMRRO_RESP_OKAY);
        $display("test reset and return done");
        stop_test();
    end
endmodule : test_cpu_move_return_reset_ops

bind cmrro_exec cmrro_exec_chk cmrro_exec_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .stack_top(stack_top), .stack_pop(stack_pop), .pc(pc), .pc_load(pc_load), .mem_wr(mem_wr),
    .option_reg(option_reg), .irq_control_reg(irq_control_reg), .soft_reset_flag(soft_reset_flag),
    .soft_reset_req(soft_reset_req));

`default_nettype wire
